//--- core/cec_comparator_event_control.sv
// comparator event control block with wishbone register slave
//
// Behaviour
// - output state reads one when positive input exceeds negative input
// - bit 5 shows live comparator output, read-only, never latched
// - bit 7 powers comparator off, writable any time
// - bit 6 is reserved and always reads zero
// - bit 4 flag sets on event matching selected mode
// - irq request only when flag, enable bit 3 and global enable
// - flag cleared by hardware when interrupt vector executes
// - writing one to flag clears it; zero leaves it
// - single-bit set/clear of other bit also clears a set flag
// - bit 2 routes comparator output to timer capture front end
// - mode bits 1:0: 00 toggle, 01 reserved, 10 falling, 11 rising
`timescale 1ns/100ps
module cec_comparator_event_control (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // comparator analog front end
  input wire logic comparatorRaw,
  output logic comparatorPowerOff,
  // processor side
  input wire logic globalIrqEnable,
  input wire logic vectorAck,
  output logic comparatorIrq,
  // timer capture front end
  output logic captureSource
);
  // ------------------------------------------------
  // synchronisation and edges
  // ------------------------------------------------
  logic compSync;
  logic compRise;
  logic compFall;

  cec_sync u_sync (
    .clock(clock),
    .rst(rst),
    .asyncIn(comparatorRaw),
    .syncOut(compSync),
    .riseOut(compRise),
    .fallOut(compFall)
  );

  // ------------------------------------------------
  // control bits
  // ------------------------------------------------
  logic powerOff_r;
  logic irqEnable_r;
  logic captureRoute_r;
  logic [1:0] mode_r;
  logic eventFlag_r;
  logic [7:0] statusByte;

  function automatic logic modeEvent(input logic [1:0] mode, input logic rise,
                                     input logic fall);
    logic hit;
    hit = 1'b0;
    case (mode)
      cec_pkg::MODE_TOGGLE: hit = rise | fall;
      cec_pkg::MODE_FALLING: hit = fall;
      cec_pkg::MODE_RISING: hit = rise;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic compEvent;
  assign compEvent = modeEvent(mode_r, compRise, compFall);

  // ------------------------------------------------
  // bus decode
  // ------------------------------------------------
  logic busReq;
  logic busDone;
  logic hitCtrl;
  logic hitCmd;
  logic wrCtrl;
  logic wrCmd;
  logic cmdSet;
  logic cmdClr;
  logic [2:0] cmdIdx;
  logic [7:0] cmdByte;
  logic [7:0] wrByte;

  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign hitCtrl = (wb_adr_i == cec_pkg::CTRL_STATUS_OFFSET);
  assign hitCmd = (wb_adr_i == cec_pkg::CMD_OFFSET);
  // writes commit at the edge where the master samples ack
  assign busDone = wb_cyc_i & wb_stb_i & wb_ack_o;
  assign wrCtrl = busDone & hitCtrl & wb_we_i & wb_sel_i[0];
  assign wrCmd = busDone & hitCmd & wb_we_i & wb_sel_i[0];
  assign cmdSet = wb_dat_i[cec_pkg::CMD_SET_BIT];
  assign cmdClr = wb_dat_i[cec_pkg::CMD_CLR_BIT];
  assign cmdIdx = wb_dat_i[cec_pkg::CMD_IDX_LO +: 3];

  // read-modify-write image for single-bit commands
  always_comb begin
    cmdByte = statusByte;
    if (cmdSet) begin
      cmdByte[cmdIdx] = 1'b1;
    end else if (cmdClr) begin
      cmdByte[cmdIdx] = 1'b0;
    end
  end

  logic cmdValid;
  assign cmdValid = wrCmd & (cmdSet | cmdClr);
  assign wrByte = wrCtrl ? wb_dat_i[7:0] : cmdByte;

  // ------------------------------------------------
  // control register
  // ------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      powerOff_r <= cec_pkg::POWER_OFF_RESET;
      irqEnable_r <= cec_pkg::IRQ_ENABLE_RESET;
      captureRoute_r <= cec_pkg::CAPTURE_ROUTE_RESET;
      mode_r <= cec_pkg::MODE_RESET;
    end else if (wrCtrl | cmdValid) begin
      powerOff_r <= wrByte[cec_pkg::POWER_OFF_BIT];
      irqEnable_r <= wrByte[cec_pkg::IRQ_ENABLE_BIT];
      captureRoute_r <= wrByte[cec_pkg::CAPTURE_ROUTE_BIT];
      mode_r <= {wrByte[cec_pkg::MODE_HI_BIT], wrByte[cec_pkg::MODE_LO_BIT]};
    end
  end

  // ------------------------------------------------
  // event flag
  // ------------------------------------------------
  logic flagClear;
  assign flagClear = vectorAck
    | ((wrCtrl | cmdValid) & wrByte[cec_pkg::EVENT_FLAG_BIT]);

  always_ff @(posedge clock) begin
    if (rst) begin
      eventFlag_r <= 1'b0;
    end else if (compEvent) begin
      eventFlag_r <= 1'b1;
    end else if (flagClear) begin
      eventFlag_r <= 1'b0;
    end
  end

  // ------------------------------------------------
  // status image
  // ------------------------------------------------
  always_comb begin
    statusByte = 8'h00;
    statusByte[cec_pkg::POWER_OFF_BIT] = powerOff_r;
    statusByte[cec_pkg::RESERVED_BIT] = 1'b0;
    statusByte[cec_pkg::OUTPUT_STATE_BIT] = compSync;
    statusByte[cec_pkg::EVENT_FLAG_BIT] = eventFlag_r;
    statusByte[cec_pkg::IRQ_ENABLE_BIT] = irqEnable_r;
    statusByte[cec_pkg::CAPTURE_ROUTE_BIT] = captureRoute_r;
    statusByte[cec_pkg::MODE_HI_BIT] = mode_r[1];
    statusByte[cec_pkg::MODE_LO_BIT] = mode_r[0];
  end

  // ------------------------------------------------
  // bus answer
  // ------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq & (hitCtrl | hitCmd);
      wb_err_o <= busReq & ~hitCtrl & ~hitCmd;
      if (busReq & hitCtrl & ~wb_we_i) begin
        wb_dat_o <= {24'h00_0000, statusByte};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------
  // outputs
  // ------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      comparatorPowerOff <= 1'b0;
      comparatorIrq <= 1'b0;
      captureSource <= 1'b0;
    end else begin
      comparatorPowerOff <= powerOff_r;
      comparatorIrq <= eventFlag_r & irqEnable_r & globalIrqEnable
        & ~flagClear;
      captureSource <= captureRoute_r & compSync;
    end
  end
endmodule // cec_comparator_event_control

//--- shared/cec_pkg.sv
// comparator event control package
package cec_pkg;
  // ------------------------------------------------
  // register map
  // ------------------------------------------------
  localparam logic [31:0] CTRL_STATUS_OFFSET = 32'h0000_0000;
  localparam logic [31:0] CMD_OFFSET = 32'h0000_0004;
  // ------------------------------------------------
  // control/status field positions
  // ------------------------------------------------
  localparam int POWER_OFF_BIT = 7;
  localparam int RESERVED_BIT = 6;
  localparam int OUTPUT_STATE_BIT = 5;
  localparam int EVENT_FLAG_BIT = 4;
  localparam int IRQ_ENABLE_BIT = 3;
  localparam int CAPTURE_ROUTE_BIT = 2;
  localparam int MODE_HI_BIT = 1;
  localparam int MODE_LO_BIT = 0;
  // command register: bit 0 set, bit 1 clear, bits 4:2 bit index
  localparam int CMD_SET_BIT = 0;
  localparam int CMD_CLR_BIT = 1;
  localparam int CMD_IDX_LO = 2;
  // ------------------------------------------------
  // reset values
  // ------------------------------------------------
  localparam logic POWER_OFF_RESET = 1'b0;
  localparam logic IRQ_ENABLE_RESET = 1'b0;
  localparam logic CAPTURE_ROUTE_RESET = 1'b0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  // ------------------------------------------------
  // event modes
  // ------------------------------------------------
  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_FALLING = 2'h2;
  localparam logic [1:0] MODE_RISING = 2'h3;
endpackage

//--- core/cec_sync.sv
// two flip-flop synchroniser with edge detection
`timescale 1ns/100ps
module cec_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // asynchronous input
  input wire logic asyncIn,
  // synchronised level and edges
  output logic syncOut,
  output logic riseOut,
  output logic fallOut
);
  logic stage1_r;
  logic stage2_r;
  logic prev_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
      prev_r <= stage2_r;
    end
  end

  assign syncOut = stage2_r;
  assign riseOut = stage2_r & ~prev_r;
  assign fallOut = ~stage2_r & prev_r;
endmodule // cec_sync

//--- verif/cec_sva.sv
// assertion checker for the comparator event block
`timescale 1ns/100ps
module cec_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // comparator and processor side
  input wire logic comparatorRaw,
  input wire logic comparatorPowerOff,
  input wire logic globalIrqEnable,
  input wire logic vectorAck,
  input wire logic comparatorIrq,
  input wire logic captureSource
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic ctlWr;
  logic ctlRd;
  assign ctlWr = wb_ack_o && wb_we_i && wb_adr_i == cec_pkg::CTRL_STATUS_OFFSET && wb_sel_i[0];
  assign ctlRd = wb_ack_o && !wb_we_i && wb_adr_i == cec_pkg::CTRL_STATUS_OFFSET;
  sequence rawSteady;
    $stable(comparatorRaw)[*6];
  endsequence
  ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o)
    else $error("request not answered");
  reserved_zero_a: assert property (ctlRd |-> {wb_dat_o[31:8], wb_dat_o[6]} == 25'h0)
    else $error("reserved bits not zero");
  live_state_a: assert property (rawSteady ##0 ctlRd |-> wb_dat_o[5] == comparatorRaw)
    else $error("output state bit wrong");
  power_copy_a: assert property (ctlWr |-> ##2 comparatorPowerOff == $past(wb_dat_i[7], 2))
    else $error("power off not following write");
  route_off_a: assert property (ctlWr && !wb_dat_i[2] |-> ##2 !captureSource)
    else $error("capture route not cut");
  irq_gate_a: assert property (comparatorIrq |-> $past(globalIrqEnable))
    else $error("irq without global enable");
  vector_clr_a: assert property (vectorAck |=> !comparatorIrq)
    else $error("irq kept after vector");
endmodule // cec_sva

//--- verif/cec_comparator_event_control_bench.sv
// self-checking bench for the comparator event block
`timescale 1ns/100ps
module cec_comparator_event_control_bench;
  logic clock = 1'b0, rst = 1'b1, raw = 1'b0, glob = 1'b1, vecAck = 1'b0;
  logic wbCyc = 1'b0, wbWe = 1'b0, ack, err, powerOff, irq, capture, er, exp;
  logic [31:0] wbAdr = 32'h0, wbDat = 32'h0, datO, rd;
  logic [3:0] wbSel = 4'h1;
  int fails = 0;
  int numChecks = 0;
  always #4 clock = ~clock;
  cec_comparator_event_control cec_comparator_event_control_i (.clock(clock), .rst(rst),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbCyc), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDat), .wb_dat_o(datO), .wb_ack_o(ack), .wb_err_o(err), .comparatorRaw(raw),
    .comparatorPowerOff(powerOff), .globalIrqEnable(glob), .vectorAck(vecAck),
    .comparatorIrq(irq), .captureSource(capture));
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    numChecks++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic bus(input logic we, input logic [31:0] adr, input logic [7:0] d);
    wbCyc <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDat <= {24'h0, d};
    do begin
      @(posedge clock);
    end while (!(ack || err));
    rd = datO;
    er = err;
    wbCyc <= 1'b0;
    @(posedge clock);
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ------------------------------------------------
  // tests
  // ------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bus(1'b0, 32'h0, 8'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    for (int m = 0; m < 4; m++) begin
      for (int e = 1; e >= 0; e--) begin
        bus(1'b1, 32'h0, 8'h10 | {6'h0, rd[1:0]});
        bus(1'b1, 32'h0, 8'h10 | 8'(m));
        bus(1'b1, 32'h0, 8'h18 | 8'(m));
        raw <= e[0];
        repeat (6) @(posedge clock);
        exp = (m == 0) || (m == 3 && e == 1) || (m == 2 && e == 0);
        chk(irq, exp);
        bus(1'b0, 32'h0, 8'h0);
        chk(rd, {26'h0, e[0], exp, 2'b10, 2'(m)});
      end
    end
    $display("mode test done");
    raw <= 1'b1;
    repeat (6) @(posedge clock);
    chk(irq, 1'b1);
    glob <= 1'b0;
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
    glob <= 1'b1;
    vecAck <= 1'b1;
    @(posedge clock);
    vecAck <= 1'b0;
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
    bus(1'b1, 32'h0, 8'h13);
    bus(1'b1, 32'h0, 8'h10);
    bus(1'b1, 32'h0, 8'h18);
    raw <= 1'b0;
    repeat (6) @(posedge clock);
    bus(1'b1, 32'h0, 8'h08);
    bus(1'b0, 32'h0, 8'h0);
    chk(rd, 32'h18);
    bus(1'b1, cec_pkg::CMD_OFFSET, 8'h09);
    bus(1'b0, 32'h0, 8'h0);
    chk(rd, 32'h0c);
    raw <= 1'b1;
    repeat (6) @(posedge clock);
    chk(capture, 1'b1);
    $display("flag test done");
    bus(1'b1, 32'h0, 8'h04);
    bus(1'b1, 32'h0, 8'hc0);
    bus(1'b0, 32'h0, 8'h0);
    chk(rd, 32'hb0);
    chk(powerOff, 1'b1);
    chk(capture, 1'b0);
    bus(1'b0, 32'h8, 8'h0);
    chk(er, 1'b1);
    wbSel <= 4'h0;
    bus(1'b1, 32'h0, 8'h00);
    wbSel <= 4'h1;
    bus(1'b0, 32'h0, 8'h0);
    chk(rd, 32'hb0);
    $display("power test done");
    completeRun();
  end
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    completeRun();
  end
endmodule // cec_comparator_event_control_bench
bind cec_comparator_event_control cec_sva cec_sva_i (.clock(clock), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .comparatorRaw(comparatorRaw), .comparatorPowerOff(comparatorPowerOff),
  .globalIrqEnable(globalIrqEnable), .vectorAck(vectorAck), .comparatorIrq(comparatorIrq),
  .captureSource(captureSource));
